// file: pkg/rmpc_regs.vh
// constants for the reset manager and regulator control block
// assumes a single 100 MHz clock domain; included by bare name
`ifndef RMPC_REGS_VH
`define RMPC_REGS_VH

// reset release stretch, in input clock and halved clock cycles
`define RMPC_RELEASE_CLK_CYCLES   12'd2048
`define RMPC_RELEASE_HALF_CYCLES  4'd8

// cause flag field positions in the clock flag register image
`define RMPC_CAUSE_SW_BIT         0
`define RMPC_CAUSE_WDG_BIT        1
`define RMPC_CAUSE_WAKE_BIT       2
`define RMPC_CAUSE_RTC_BIT        3
`define RMPC_CAUSE_WIDTH          4

// reset values
`define RMPC_CAUSE_RESET          4'h0
`define RMPC_HALVE_SEL_RESET      1'b1
`define RMPC_RESET_VECTOR_ADDR    32'h00000000

// regulator settle time, in cycles of the 10 ns clock
`define RMPC_SETTLE_NS            1000
`define RMPC_CLK_PERIOD_NS        10
`define RMPC_SETTLE_CYCLES  ((`RMPC_SETTLE_NS + `RMPC_CLK_PERIOD_NS - 1) / `RMPC_CLK_PERIOD_NS)

`endif

// file: core/rmpc_release_cnt.v
// reset release counter: holds reset for a fixed count after all sources go
// away; assumes sources are already synchronous to clk
`timescale 1ns/1ps
`include "rmpc_regs.vh"

module rmpc_release_cnt #(
    parameter CLK_CYCLES  = 2048,
    parameter HALF_CYCLES = 8
)(
    // clock and reset
    input  wire        clk,
    input  wire        rst_n,
    // control
    input  wire        src_active,
    input  wire        halve_sel,
    // status
    output reg         in_reset_q
);

    localparam CW = 14;
    // worst case total: clock cycles plus two clocks per halved cycle
    localparam integer  TOTAL_DIV_I = CLK_CYCLES + 2 * HALF_CYCLES;
    localparam integer  TOTAL_ONE_I = CLK_CYCLES + HALF_CYCLES;
    // counter is sized for the documented count; cut the sums on purpose
    localparam [CW-1:0] TOTAL_DIV = TOTAL_DIV_I[CW-1:0];
    localparam [CW-1:0] TOTAL_ONE = TOTAL_ONE_I[CW-1:0];

    reg [CW-1:0] cnt_q;
    wire [CW-1:0] target = halve_sel ? TOTAL_DIV : TOTAL_ONE;

    // restart from zero whenever any source comes back mid-count
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_q      <= {CW{1'b0}};
            in_reset_q <= 1'b1;
        end
        else if (src_active)
        begin
            cnt_q      <= {CW{1'b0}};
            in_reset_q <= 1'b1;
        end
        else if (in_reset_q)
        begin
            if (cnt_q == target - 14'h0001)
                in_reset_q <= 1'b0;
            cnt_q <= cnt_q + 14'h0001;
        end
    end

endmodule // rmpc_release_cnt

// file: core/rmpc_reset_power.v
// reset manager and regulator control: merges reset sources, records the
// cause, stretches release, sequences main regulator and pll gating
// assumes all inputs except ext_reset_pin_n are synchronous to clk
`timescale 1ns/1ps
`include "rmpc_regs.vh"

// What this block does
// - low external pin puts device in reset
// - software trigger resets only when both enabled
// - held in reset while supply detector low
// - watchdog expiry without code causes reset
// - wake pin in standby causes reset
// - rtc alarm in standby causes reset
// - flag records source of last reset
// - pin or low-voltage reset clears all flags
// - external pin overrides all, loads defaults
// - pin reset acts asynchronously, no clock
// - release after 2048 clk plus 8 halved
// - program counter loads vector at zero
// - main regulator off in standby
// - optional main regulator off in stop/wait
// - bypass bit turns regulator off, pll disabled
// - stable flag only after regulator settles
// - main regulator off forces pll off
// - standby isolates core from backup domain
// - software may bypass low-power regulator
// - halved clock is clk/2 when select set
module rmpc_reset_power #(
    parameter CLK_CYCLES    = 2048,
    parameter HALF_CYCLES   = 8,
    parameter SETTLE_CYCLES = `RMPC_SETTLE_CYCLES
)(
    // clock and reset
    input  wire        clk,
    input  wire        rst_n,
    input  wire        ext_reset_pin_n,
    // reset sources
    input  wire        sw_reset_trigger,
    input  wire        sw_reset_enable,
    input  wire        halt_enable,
    input  wire        main_lvd_low,
    input  wire        backup_lvd_low,
    input  wire        wdg_mode_en,
    input  wire        wdg_expired,
    input  wire        wake_pin,
    input  wire        rtc_alarm,
    // mode and power control
    input  wire        standby_mode,
    input  wire        stop_mode,
    input  wire        low_power_wait_mode,
    input  wire        main_reg_off_in_lowpower,
    input  wire        main_reg_bypass,
    input  wire        lp_reg_bypass_req,
    input  wire        main_reg_ready,
    input  wire        input_halve_select,
    input  wire        pll_enable_req,
    // reset outputs
    output reg         sys_reset_n_q,
    output reg         io_reset_cfg_q,
    output reg         pc_load_q,
    output reg  [31:0] pc_vector_addr_q,
    output reg  [3:0]  reset_cause_q,
    // power outputs
    output reg         main_regulator_en_q,
    output reg         main_reg_stable_q,
    output reg         pll_enable_q,
    output reg         lp_reg_en_q,
    output reg         domain_connect_q,
    output reg         halved_input_clock_q
);

    // combined reset for the merged core: pin acts without the clock
    wire arst_n = rst_n & ext_reset_pin_n;

    // software reset needs both enables set in the same cycle as the trigger
    wire sw_src  = sw_reset_trigger & sw_reset_enable & halt_enable;
    wire lvd_src = main_lvd_low | backup_lvd_low;
    wire wdg_src = wdg_mode_en & wdg_expired;
    wire wake_src = standby_mode & wake_pin;
    wire rtc_src  = standby_mode & rtc_alarm;
    wire any_src  = sw_src | lvd_src | wdg_src | wake_src | rtc_src;

    wire in_reset;

    // release stretch; a sync source reasserting restarts the count
    rmpc_release_cnt #(
        .CLK_CYCLES  (CLK_CYCLES),
        .HALF_CYCLES (HALF_CYCLES)
    ) u_release (
        .clk        (clk),
        .rst_n      (arst_n),
        .src_active (any_src),
        .halve_sel  (input_halve_select),
        .in_reset_q (in_reset)
    );

    // cause flags are replaced, not cleared, by internal resets; only rst_n, pin or lvd clears them
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            reset_cause_q <= `RMPC_CAUSE_RESET;
        else if (lvd_src)
            reset_cause_q <= `RMPC_CAUSE_RESET;
        else if (any_src & ~in_reset)
        begin
            // new reset event: record only its own source
            reset_cause_q <= {rtc_src, wake_src, wdg_src, sw_src};
        end
        else if (any_src)
        begin
            // further sources during a reset also record, set wins
            reset_cause_q <= reset_cause_q |
                             {rtc_src, wake_src, wdg_src, sw_src};
        end
    end

    // system reset outputs and reset-vector load pulse
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sys_reset_n_q    <= 1'b0;
            io_reset_cfg_q   <= 1'b1;
            pc_load_q        <= 1'b0;
            pc_vector_addr_q <= `RMPC_RESET_VECTOR_ADDR;
        end
        else
        begin
            sys_reset_n_q    <= ~in_reset;
            io_reset_cfg_q   <= in_reset;
            // one pulse on the cycle reset lifts
            pc_load_q        <= in_reset & ~sys_reset_n_q ? 1'b0 :
                                (~in_reset & ~sys_reset_n_q);
            pc_vector_addr_q <= `RMPC_RESET_VECTOR_ADDR;
        end
    end

    // main regulator request: off in standby, bypass, or lowpower option
    wire reg_off = standby_mode
                 | main_reg_bypass
                 | (main_reg_off_in_lowpower
                    & (stop_mode | low_power_wait_mode));

    // settle counter; the ready input alone is not trusted
    localparam SW = 16;
    localparam integer  SETTLE_I = SETTLE_CYCLES;
    localparam [SW-1:0] SETTLE = SETTLE_I[SW-1:0];
    reg [SW-1:0] settle_q;

    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            main_regulator_en_q <= 1'b1;
            settle_q            <= {SW{1'b0}};
            main_reg_stable_q   <= 1'b0;
        end
        else
        begin
            main_regulator_en_q <= ~reg_off;
            if (reg_off | ~main_reg_ready)
            begin
                settle_q          <= {SW{1'b0}};
                main_reg_stable_q <= 1'b0;
            end
            else if (settle_q != SETTLE)
                settle_q <= settle_q + 16'h0001;
            else
                main_reg_stable_q <= 1'b1;
        end
    end

    // pll forced off whenever main regulator is off
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            pll_enable_q <= 1'b0;
        else
            pll_enable_q <= pll_enable_req & ~reg_off;
    end

    // domain isolation and low-power regulator bypass
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            domain_connect_q <= 1'b1;
            lp_reg_en_q      <= 1'b1;
        end
        else
        begin
            domain_connect_q <= ~standby_mode;
            lp_reg_en_q      <= ~lp_reg_bypass_req;
        end
    end

    // halved clock: toggles when select set, held high otherwise
    // as a flop output it can only mark clk/2; undivided mode reads high
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            halved_input_clock_q <= 1'b0;
        else if (input_halve_select)
            halved_input_clock_q <= ~halved_input_clock_q;
        else
            halved_input_clock_q <= 1'b1;
    end

endmodule // rmpc_reset_power

// file: verif/rmpc_reset_power_props.sv
// assertions on the reset manager ports
// bound to every rmpc_reset_power instance; one clk domain
`timescale 1ns/1ps
module rmpc_props (
    // clock, reset and sources
    input wire        clk,
    input wire        rst_n,
    input wire        ext_reset_pin_n,
    input wire        sw_reset_trigger,
    input wire        sw_reset_enable,
    input wire        halt_enable,
    input wire        wdg_mode_en,
    input wire        wdg_expired,
    input wire        wake_pin,
    input wire        standby_mode,
    // observed outputs
    input wire        sys_reset_n_q,
    input wire        pc_load_q,
    input wire [31:0] pc_vector_addr_q,
    input wire [3:0]  reset_cause_q,
    input wire        main_regulator_en_q,
    input wire        pll_enable_q,
    input wire        domain_connect_q
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // sync sources reach the reset output two edges after sampling
    property p_pin;
        !ext_reset_pin_n |-> !sys_reset_n_q && reset_cause_q == 4'h0;
    endproperty
    a_pin: assert property (p_pin) else $error("pin reset missed");
    property p_sw;
        sw_reset_trigger && sw_reset_enable && halt_enable |->
            ##2 !sys_reset_n_q && reset_cause_q == 4'h1;
    endproperty
    a_sw: assert property (p_sw) else $error("sw reset missed");
    property p_wdg;
        wdg_mode_en && wdg_expired |->
            ##2 !sys_reset_n_q && reset_cause_q == 4'h2;
    endproperty
    a_wdg: assert property (p_wdg) else $error("wdg reset missed");
    property p_wake;
        standby_mode && wake_pin |->
            ##2 !sys_reset_n_q && reset_cause_q == 4'h4;
    endproperty
    a_wake: assert property (p_wake) else $error("wake reset missed");
    property p_pc;
        $rose(sys_reset_n_q) |-> pc_load_q && pc_vector_addr_q == 32'h0;
    endproperty
    a_pc: assert property (p_pc) else $error("vector load missed");
    property p_stby;
        sys_reset_n_q && standby_mode |=> !main_regulator_en_q || !sys_reset_n_q;
    endproperty
    a_stby: assert property (p_stby) else $error("regulator on");
    // one cycle of slack, though the pll flop switches on the same edge as the regulator flop
    property p_pll;
        !main_regulator_en_q && $past(!main_regulator_en_q) |-> !pll_enable_q;
    endproperty
    a_pll: assert property (p_pll) else $error("pll left on");
    property p_iso;
        sys_reset_n_q && $past(sys_reset_n_q) |->
            domain_connect_q == !$past(standby_mode);
    endproperty
    a_iso: assert property (p_iso) else $error("domain link wrong");
    c_rel: cover property ($rose(sys_reset_n_q));
    c_wake: cover property (standby_mode && wake_pin);
    c_off: cover property (!main_regulator_en_q);
endmodule // rmpc_props

bind rmpc_reset_power rmpc_props u_props (.clk(clk), .rst_n(rst_n),
    .ext_reset_pin_n(ext_reset_pin_n), .sw_reset_trigger(sw_reset_trigger),
    .sw_reset_enable(sw_reset_enable), .halt_enable(halt_enable),
    .wdg_mode_en(wdg_mode_en), .wdg_expired(wdg_expired),
    .wake_pin(wake_pin), .standby_mode(standby_mode),
    .sys_reset_n_q(sys_reset_n_q), .pc_load_q(pc_load_q),
    .pc_vector_addr_q(pc_vector_addr_q), .reset_cause_q(reset_cause_q),
    .main_regulator_en_q(main_regulator_en_q), .pll_enable_q(pll_enable_q),
    .domain_connect_q(domain_connect_q));

// file: verif/rmpc_supply_model.sv
// external reset circuit and board supplies
// requests come from the bench on clk; ready ramps after enable
`timescale 1ns/1ps
module rmpc_supply_model #(
    parameter RAMP = 5
)(
    // clock and bench requests
    input  wire clk,
    input  wire pin_req,
    input  wire drop_req,
    // supply side
    input  wire reg_en,
    output reg  pin_n = 1'b0,
    output reg  lvd_low = 1'b0,
    output reg  ready = 1'b0
);
    reg [3:0] ramp_q = 4'h0;
    // regulator output needs time to settle, so ready lags the enable
    always @(posedge clk)
    begin
        pin_n   <= !pin_req;
        lvd_low <= drop_req;
        ramp_q  <= reg_en ? ramp_q + {3'h0, ramp_q != RAMP} : 4'h0;
        ready   <= reg_en && ramp_q == RAMP;
    end
endmodule // rmpc_supply_model

// file: verif/tb.sv
// self-checking bench for the reset manager and regulator control
// assumes the supply model and the bound checker are compiled first
`timescale 1ns/1ps
module tb;
    localparam [13:0] TBL [0:7] = '{14'h2207, 14'h0003, 14'h2430,
        14'h0020, 14'h2940, 14'h3180, 14'h0040, 14'h2008};
    reg        clk = 1'b0;
    reg        rst_n = 1'b0;
    reg  [8:0] s = 9'h0;
    reg  [6:0] p = 7'h20;
    reg        pin_req = 1'b1;
    reg        drop_req = 1'b0;
    reg  [3:0] q [$];
    reg  [3:0] exp_c;
    reg        h;
    integer    seed = 32'hbf85;
    integer    num_errors = 0;
    integer    n_compared = 0;
    integer    cyc = 0;
    integer    i, n;
    wire       pin_n, lvd, rdy, sys_n, pcl, reg_en, stable, pll, conn, half;
    wire       iocfg, lpen;
    wire [31:0] vec;
    wire [3:0] cause;
    always #5 clk = !clk;
    rmpc_supply_model u_sup (.clk(clk), .pin_req(pin_req),
        .drop_req(drop_req), .reg_en(reg_en), .pin_n(pin_n),
        .lvd_low(lvd), .ready(rdy));
    rmpc_reset_power #(.CLK_CYCLES(16), .HALF_CYCLES(2),
        .SETTLE_CYCLES(4)) uut (.clk(clk), .rst_n(rst_n),
        .ext_reset_pin_n(pin_n), .sw_reset_trigger(s[0]),
        .sw_reset_enable(s[1]), .halt_enable(s[2]), .main_lvd_low(lvd),
        .backup_lvd_low(s[3]), .wdg_mode_en(s[4]), .wdg_expired(s[5]),
        .wake_pin(s[6]), .rtc_alarm(s[7]), .standby_mode(s[8]),
        .stop_mode(p[0]), .low_power_wait_mode(p[1]),
        .main_reg_off_in_lowpower(p[2]), .main_reg_bypass(p[3]),
        .lp_reg_bypass_req(p[4]), .main_reg_ready(rdy),
        .input_halve_select(p[5]), .pll_enable_req(p[6]),
        .sys_reset_n_q(sys_n), .io_reset_cfg_q(iocfg), .pc_load_q(pcl),
        .pc_vector_addr_q(vec), .reset_cause_q(cause),
        .main_regulator_en_q(reg_en), .main_reg_stable_q(stable),
        .pll_enable_q(pll), .lp_reg_en_q(lpen), .domain_connect_q(conn),
        .halved_input_clock_q(half));
    task complete_run;
    begin
        if (num_errors == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    end
    endtask
    task check(input ok);
    begin
        n_compared = n_compared + 1;
        if (!ok)
        begin
            num_errors = num_errors + 1;
            $display("mismatch at %0t: unexpected port value", $time);
        end
    end
    endtask
    // wait for noted releases, then watch a while for stray resets
    task settle;
    begin
        for (n = 0; n < 80 && q.size() != 0; n = n + 1) @(posedge clk);
        repeat (30) @(posedge clk);
        check(q.size() == 0);
    end
    endtask
    task fire(input [13:0] e);
    begin
        if (e[13])
            q.push_back(e[12:9]);
        @(posedge clk) s <= e[8:0];
        repeat ({$random(seed)} % 3) @(posedge clk);
        @(posedge clk) s <= 9'h0;
        settle;
    end
    endtask
    // each release pulse is matched against the oldest noted cause
    always @(negedge clk)
    begin
        if (pcl === 1'b1)
        begin
            exp_c = (q.size() != 0) ? q.pop_front() : 4'hx;
            check(cause === exp_c && vec === 32'h0);
            check(sys_n === 1'b1 && iocfg === 1'b0);
        end
    end
    // hang guard
    always @(posedge clk)
    begin
        cyc = cyc + 1;
        if (cyc == 3000)
        begin
            num_errors = num_errors + 1;
            complete_run;
        end
    end
    initial
    begin
        q.push_back(4'h0);
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        pin_req <= 1'b0;
        settle;
        for (i = 0; i < 8; i = i + 1)
            fire(TBL[i]);
        // a second drop mid-stretch must give a single release
        q.push_back(4'h0);
        drop_req <= 1'b1;
        repeat (3) @(posedge clk);
        drop_req <= 1'b0;
        repeat (8) @(posedge clk);
        drop_req <= 1'b1;
        @(posedge clk) drop_req <= 1'b0;
        settle;
        q.push_back(4'h0);
        pin_req <= 1'b1;
        repeat (3) @(posedge clk);
        pin_req <= 1'b0;
        for (n = 0; n < 99 && pcl !== 1'b1; n = n + 1) @(negedge clk);
        check(n >= 20 && n <= 24);
        settle;
        p <= 7'h48;
        repeat (3) @(negedge clk);
        check(reg_en === 1'b0 && pll === 1'b0 && half === 1'b1);
        @(posedge clk) p <= 7'h65;
        repeat (3) @(negedge clk);
        check(reg_en === 1'b0 && conn === 1'b1);
        @(posedge clk) p <= 7'h20 | ({$random(seed)} & 7'h50);
        for (n = 0; n < 60 && stable !== 1'b1; n = n + 1) @(negedge clk);
        check(stable === 1'b1 && rdy === 1'b1 && reg_en === 1'b1);
        check(lpen === !p[4] && pll === p[6]);
        h = half;
        @(negedge clk);
        check(half === !h);
        complete_run;
    end
endmodule // tb
